/* File: src/rla_ctrl.sv */
// Remote/local state and primary/secondary address control
`timescale 1ns/1ps
module rla_ctrl (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Link status pins and interface choice
    input wire logic iface_sel_i,
    input wire logic ren_i,
    input wire logic ser_char_i,
    input wire logic bus_gtl_i,
    input wire logic [4:0] bus_addr_i,
    // Front panel
    input wire logic panel_local_i,
    input wire logic loc_pri_wr_i,
    input wire logic [4:0] loc_pri_addr_i,
    input wire logic loc_sec_wr_i,
    input wire logic [4:0] loc_sec_idx_i,
    input wire logic [4:0] loc_sec_grp_i,
    // Remote setting commands
    input wire logic rem_pri_wr_i,
    input wire logic [4:0] rem_pri_addr_i,
    input wire logic rem_sec_wr_i,
    input wire logic [4:0] rem_sec_idx_i,
    input wire logic [4:0] rem_sec_grp_i,
    input wire logic rem_compat_wr_i,
    input wire logic rem_compat_val_i,
    // Command routing
    input wire logic cmd_vld_i,
    input wire logic cmd_hw_vld_i,
    input wire logic [4:0] cmd_hw_sec_i,
    input wire logic cmd_pfx_vld_i,
    input wire logic [4:0] cmd_pfx_sec_i,
    input wire logic sec_sel_vld_i,
    input wire logic [4:0] sec_sel_addr_i,
    input wire logic sig_mode_i,
    // State outputs
    output logic remote_o,
    output logic panel_lock_o,
    output logic [4:0] pri_addr_o,
    output logic addr_match_o,
    output logic compat_o,
    output logic [4:0] active_sec_o,
    output logic gen_off_o,
    output logic sig_reset_o,
    output logic set_rej_o,
    // Routed command
    output logic route_vld_o,
    output logic [4:0] route_grp_o,
    output logic route_err_o
);

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        logic ren_s1;
        logic ren_s2;
        logic ren_s3;
        logic loc_s1;
        logic loc_s2;
        logic loc_s3;
        rla_pkg::rla_state_t st;
        logic [4:0] pri;
        logic compat;
        logic [4:0] act_sec;
        logic [30:0][4:0] grp;
        logic match;
        logic gen_off;
        logic sig_rst;
        logic rej;
        logic rt_vld;
        logic [4:0] rt_grp;
        logic rt_err;
    } rla_regs_t;

    // Whole state in one record, registered by a single process
    rla_regs_t s_q;
    rla_regs_t s_d;

    // Address fits in range lo..hi
    function automatic logic rla_in_range(input logic [4:0] a, input logic [4:0] lo,
                                          input logic [4:0] hi);
        rla_in_range = (a >= lo) && (a <= hi);
    endfunction : rla_in_range

    // Secondary address defined: in table and holding a group
    function automatic logic rla_sec_defined(input logic [4:0] a,
                                             input logic [30:0][4:0] tbl);
        rla_sec_defined = (a <= rla_pkg::RLA_SEC_MAX) && (tbl[a] != rla_pkg::RLA_GRP_NONE);
    endfunction : rla_sec_defined

    // Remote state decode, shared by the machine and the lock outputs
    function automatic logic rla_is_remote(input rla_pkg::rla_state_t st);
        rla_is_remote = (st == rla_pkg::RLA_ST_REMOTE);
    endfunction : rla_is_remote

    logic ren_rise;
    logic loc_rise;
    logic go_remote;
    logic go_local;
    logic is_remote;
    logic [4:0] eff_sec;
    logic pri_bad;
    logic sec_bad;
    logic sel_bad;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        // REN and local key pass three flops; only the second stage and later feed logic
        // The third stage holds the previous level for the edge detectors
        s_d.ren_s1 = ren_i;
        s_d.ren_s2 = s_q.ren_s1;
        s_d.ren_s3 = s_q.ren_s2;
        s_d.loc_s1 = panel_local_i;
        s_d.loc_s2 = s_q.loc_s1;
        s_d.loc_s3 = s_q.loc_s2;
        ren_rise = s_q.ren_s2 && !s_q.ren_s3;
        loc_rise = s_q.loc_s2 && !s_q.loc_s3;
        is_remote = rla_is_remote(s_q.st);

        // Remote entry per active interface
        go_remote = !is_remote &&
                    (((iface_sel_i == rla_pkg::RLA_IF_PARALLEL) && ren_rise) ||
                     ((iface_sel_i == rla_pkg::RLA_IF_SERIAL) && ser_char_i));
        // Local key is the one panel action honoured while remote
        go_local = is_remote && (loc_rise || bus_gtl_i);

        // One-cycle event pulses default low
        // Self-clearing, so no pulse outlives its cycle
        s_d.gen_off = 1'b0;
        s_d.sig_rst = 1'b0;
        s_d.rej = 1'b0;
        s_d.rt_vld = 1'b0;
        s_d.rt_err = 1'b0;

        // State machine
        case (s_q.st)
            rla_pkg::RLA_ST_LOCAL: begin
                if (go_remote) begin
                    s_d.st = rla_pkg::RLA_ST_REMOTE;
                    if (s_q.compat) begin
                        // Test state reset only when compatibility is on
                        s_d.gen_off = !sig_mode_i;
                        s_d.sig_rst = sig_mode_i;
                    end
                end
            end
            rla_pkg::RLA_ST_REMOTE: begin
                // Entry events are ignored here; only the local paths leave
                if (go_local) begin
                    s_d.st = rla_pkg::RLA_ST_LOCAL;
                end
            end
            default: begin
                s_d.st = rla_pkg::RLA_ST_LOCAL;
            end
        endcase

        // Panel writes, dropped while remote
        // Out-of-range panel values are dropped without a flag
        if (!is_remote && loc_pri_wr_i &&
            rla_in_range(loc_pri_addr_i, 5'h00, rla_pkg::RLA_PRI_MAX)) begin
            s_d.pri = loc_pri_addr_i;
        end
        if (!is_remote && loc_sec_wr_i && (loc_sec_grp_i != rla_pkg::RLA_GRP_BASE) &&
            rla_in_range(loc_sec_idx_i, rla_pkg::RLA_SEC_LOC_MIN,
                         rla_pkg::RLA_SEC_LOC_MAX)) begin
            s_d.grp[loc_sec_idx_i] = loc_sec_grp_i;
        end

        // Remote writes; out-of-range requests change nothing
        // They run in either state and win over a same-cycle panel write
        pri_bad = rem_pri_wr_i && !rla_in_range(rem_pri_addr_i, 5'h00, rla_pkg::RLA_PRI_MAX);
        sec_bad = rem_sec_wr_i && (!rla_in_range(rem_sec_idx_i, 5'h01, rla_pkg::RLA_SEC_MAX)
                  || (rem_sec_grp_i == rla_pkg::RLA_GRP_BASE));
        sel_bad = sec_sel_vld_i && !rla_sec_defined(sec_sel_addr_i, s_q.grp);
        if (rem_pri_wr_i && !pri_bad) begin
            s_d.pri = rem_pri_addr_i;
        end
        if (rem_sec_wr_i && !sec_bad) begin
            s_d.grp[rem_sec_idx_i] = rem_sec_grp_i;
        end
        if (rem_compat_wr_i) begin
            s_d.compat = rem_compat_val_i;
        end
        if (sec_sel_vld_i && !sel_bad) begin
            s_d.act_sec = sec_sel_addr_i;
        end
        s_d.rej = pri_bad || sec_bad || sel_bad;
        // Entry 0 is pinned so no path can remap the base system
        s_d.grp[rla_pkg::RLA_SEC_BASE] = rla_pkg::RLA_GRP_BASE;

        // Bus address compare: one listener/talker at the primary address
        // Compared with the stored address, so a new address counts a cycle later
        s_d.match = (bus_addr_i == s_q.pri);

        // Command routing: hardware secondary, then prefix, then active select
        // A prefix steers only its own command and leaves the select untouched
        if ((iface_sel_i == rla_pkg::RLA_IF_PARALLEL) && cmd_hw_vld_i) begin
            eff_sec = cmd_hw_sec_i;
        end else if (cmd_pfx_vld_i) begin
            eff_sec = cmd_pfx_sec_i;
        end else begin
            eff_sec = s_q.act_sec;
        end
        if (cmd_vld_i) begin
            if (rla_sec_defined(eff_sec, s_q.grp)) begin
                s_d.rt_vld = 1'b1;
                s_d.rt_grp = s_q.grp[eff_sec];
            end else begin
                s_d.rt_err = 1'b1;
            end
        end

        // Synchronous reset: local state and factory addresses
        // Placed last so it overrides any write in the same cycle
        if (sys_rst_i) begin
            s_d = '0;
            s_d.st = rla_pkg::RLA_ST_LOCAL;
            s_d.pri = rla_pkg::RLA_PRI_RST;
            s_d.compat = rla_pkg::RLA_COMPAT_RST;
            s_d.act_sec = rla_pkg::RLA_SEC_RST;
            for (int i = 0; i < rla_pkg::RLA_SEC_NUM; i++) begin
                s_d.grp[i] = rla_pkg::RLA_GRP_NONE;
            end
            s_d.grp[rla_pkg::RLA_SEC_BASE] = rla_pkg::RLA_GRP_BASE;
        end
    end

    // State register
    always_ff @(posedge clk_sys_i) begin
        s_q <= s_d;
    end

    // ------------------------------------------------------------
    // Outputs, all from flops
    // ------------------------------------------------------------
    assign remote_o = rla_is_remote(s_q.st);
    assign panel_lock_o = rla_is_remote(s_q.st);
    assign pri_addr_o = s_q.pri;
    assign addr_match_o = s_q.match;
    assign compat_o = s_q.compat;
    assign active_sec_o = s_q.act_sec;
    assign gen_off_o = s_q.gen_off;
    assign sig_reset_o = s_q.sig_rst;
    assign set_rej_o = s_q.rej;
    assign route_vld_o = s_q.rt_vld;
    assign route_grp_o = s_q.rt_grp;
    assign route_err_o = s_q.rt_err;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking rla_cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    // Primary address never leaves the legal range
    a_pri_in_range: assert property (s_q.pri <= 5'h1e)
        else $error("primary address above 30");
    // First edge after reset shows local state and address 20
    a_reset_defaults: assert property ($fell(sys_rst_i) |->
        !remote_o && s_q.pri == 5'h14)
        else $error("reset defaults wrong");
    // Base system entry can never be remapped
    a_base_pinned: assert property (s_q.grp[0] == rla_pkg::RLA_GRP_BASE)
        else $error("secondary zero lost base system");
    // Panel lock is the remote state itself
    a_lock_mirror: assert property (panel_lock_o == remote_o)
        else $error("panel lock differs from remote state");
    // Pin rise needs three edges through the synchroniser before it counts
    a_ren_enters: assert property ((iface_sel_i == 1'b0) && !ren_i ##1 ren_i [*3] ##0
        (iface_sel_i == 1'b0) && !remote_o |=> remote_o)
        else $error("remote enable did not enter remote");
    // Any serial character enters remote in the next cycle
    a_char_enters: assert property ((iface_sel_i == 1'b1) && ser_char_i && !remote_o
        |=> remote_o)
        else $error("serial character did not enter remote");
    // Panel writes are dropped while remote
    a_panel_locked: assert property (remote_o && loc_pri_wr_i && !rem_pri_wr_i
        |=> $stable(pri_addr_o))
        else $error("panel write taken while remote");
    // Only the local key or go-to-local ends remote
    a_remote_holds: assert property (remote_o && !loc_rise && !bus_gtl_i |=> remote_o)
        else $error("left remote without cause");
    // Go-to-local returns to local in the next cycle
    a_gtl_leaves: assert property (remote_o && bus_gtl_i |=> !remote_o)
        else $error("go-to-local ignored");
    // Side effect on entry follows the compatibility setting
    a_compat_effect: assert property (!remote_o ##1 remote_o |->
        (gen_off_o || sig_reset_o) == $past(s_q.compat))
        else $error("transition side effect wrong");
    // Signalling mode drops the call, test mode switches generators off
    a_sig_choice: assert property (compat_o && !remote_o && iface_sel_i && ser_char_i
        |=> sig_reset_o == $past(sig_mode_i) && gen_off_o == !$past(sig_mode_i))
        else $error("wrong entry side effect chosen");
    // No side effect with compatibility off
    a_compat_off: assert property (!compat_o |=> !gen_off_o && !sig_reset_o)
        else $error("state changed with compatibility off");
    // Compatibility write lands in the next cycle
    a_compat_write: assert property (rem_compat_wr_i
        |=> compat_o == $past(rem_compat_val_i))
        else $error("compatibility write lost");
    // Bad remote primary address is refused and flagged
    a_reject_keeps: assert property (rem_pri_wr_i && rem_pri_addr_i > 5'h1e
        && !loc_pri_wr_i |=> set_rej_o && $stable(pri_addr_o))
        else $error("bad primary address taken");
    // Good remote primary address lands in the next cycle
    a_rem_pri_take: assert property (rem_pri_wr_i && rem_pri_addr_i <= 5'h1e
        |=> pri_addr_o == $past(rem_pri_addr_i))
        else $error("remote primary write lost");
    // Remote write to secondary zero is refused
    a_sec_zero_rej: assert property (rem_sec_wr_i && rem_sec_idx_i == 5'h00
        && !loc_sec_wr_i |=> set_rej_o && $stable(s_q.grp))
        else $error("secondary zero write taken");
    // Panel cannot assign index 30 or above
    a_panel_sec_range: assert property (!remote_o && loc_sec_wr_i && loc_sec_idx_i > 5'h1d
        && !rem_sec_wr_i |=> $stable(s_q.grp))
        else $error("panel assigned index above 29");
    // Prefix on the serial link routes to its own group
    a_prefix_route: assert property (cmd_vld_i && cmd_pfx_vld_i && iface_sel_i
        && cmd_pfx_sec_i == 5'h00 |=> route_vld_o && route_grp_o == rla_pkg::RLA_GRP_BASE)
        else $error("prefix command misrouted");
    // Select to an undefined address is refused
    a_select_reject: assert property (sec_sel_vld_i && sec_sel_addr_i == 5'h1f
        |=> set_rej_o && $stable(active_sec_o))
        else $error("select to undefined address taken");
    // Command to an unassigned secondary is an error
    a_undef_error: assert property (cmd_vld_i && !cmd_hw_vld_i && !cmd_pfx_vld_i
        && s_q.grp[s_q.act_sec] == 5'h00 |=> route_err_o && !route_vld_o)
        else $error("unassigned secondary not flagged");

    // ------------------------------------------------------------
    // Cover points
    // ------------------------------------------------------------
    c_enter_remote: cover property (!remote_o ##1 remote_o);
    c_prefix_route: cover property (cmd_vld_i && cmd_pfx_vld_i ##1 route_vld_o);
    c_back_local: cover property (remote_o ##1 !remote_o);
    c_select_switch: cover property (sec_sel_vld_i ##1 $changed(active_sec_o));
    c_route_error: cover property (route_err_o);

endmodule : rla_ctrl

/* File: include/rla_pkg.sv */
// Constants and types for the remote/local and address control block
package rla_pkg;

    // ------------------------------------------------------------
    // Address limits and reset values
    // ------------------------------------------------------------
    localparam logic [4:0] RLA_PRI_MAX = 5'h1e;      // 30 decimal
    localparam logic [4:0] RLA_PRI_RST = 5'h14;      // 20 decimal
    localparam logic [4:0] RLA_SEC_MAX = 5'h1e;      // 30 decimal
    localparam logic [4:0] RLA_SEC_LOC_MIN = 5'h01;
    localparam logic [4:0] RLA_SEC_LOC_MAX = 5'h1d;  // 29 decimal
    localparam logic [4:0] RLA_SEC_BASE = 5'h00;
    localparam logic [4:0] RLA_SEC_RST = 5'h00;
    localparam int RLA_SEC_NUM = 31;

    // ------------------------------------------------------------
    // Function group codes
    // ------------------------------------------------------------
    localparam logic [4:0] RLA_GRP_NONE = 5'h00;
    localparam logic [4:0] RLA_GRP_BASE = 5'h1f;

    // ------------------------------------------------------------
    // Mode settings and interface selection
    // ------------------------------------------------------------
    localparam logic RLA_COMPAT_RST = 1'b1;
    localparam logic RLA_IF_PARALLEL = 1'b0;
    localparam logic RLA_IF_SERIAL = 1'b1;

    // Operating state, Gray ordered
    typedef enum logic [1:0] {
        RLA_ST_LOCAL = 2'b00,
        RLA_ST_REMOTE = 2'b01
    } rla_state_t;

endpackage : rla_pkg

/* File: dv/rla_host_model.sv */
// Host controller model: remote enable, serial traffic, go-to-local
`timescale 1ns/1ps
module rla_host_model (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // Requests from the bench
    input wire logic iface_sel_i,
    input wire logic want_rem_i,
    input wire logic want_loc_i,
    // Lines to the device
    output logic ren_o,
    output logic ser_char_o,
    output logic bus_gtl_o,
    output logic cmd_hw_vld_o
);
    // REN stays up until go-to-local, so a held level is what the device sees
    always_ff @(posedge clk_sys_i) begin
        if (sys_rst_i) begin
            {ren_o, ser_char_o, bus_gtl_o} <= 3'b000;
        end else begin
            ren_o <= (ren_o | (want_rem_i & ~iface_sel_i)) & ~want_loc_i;
            ser_char_o <= want_rem_i & iface_sel_i;
            bus_gtl_o <= want_loc_i & ~iface_sel_i;
        end
    end
    // Bus commands always carry a hardware secondary
    assign cmd_hw_vld_o = ~iface_sel_i;
endmodule : rla_host_model

/* File: dv/tb_remote_local_address_control.sv */
// Self-checking bench for the remote/local and address control block
`timescale 1ns/1ps
module tb_remote_local_address_control;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic clk_sys_i, sys_rst_i, iface_sel_i, panel_local_i, loc_pri_wr_i, loc_sec_wr_i;
    logic rem_pri_wr_i, rem_sec_wr_i, rem_compat_wr_i, rem_compat_val_i, cmd_vld_i;
    logic cmd_pfx_vld_i, sec_sel_vld_i, sig_mode_i, want_rem, want_loc;
    logic [4:0] bus_addr_i, loc_pri_addr_i, loc_sec_idx_i, loc_sec_grp_i, rem_pri_addr_i;
    logic [4:0] rem_sec_idx_i, rem_sec_grp_i, cmd_hw_sec_i, cmd_pfx_sec_i, sec_sel_addr_i;
    logic ren_i, ser_char_i, bus_gtl_i, cmd_hw_vld_i;
    logic remote_o, panel_lock_o, addr_match_o, compat_o, gen_off_o, sig_reset_o;
    logic set_rej_o, route_vld_o, route_err_o;
    logic [4:0] pri_addr_o, active_sec_o, route_grp_o;
    logic [31:0] rng;
    logic [4:0] tbl [32];
    logic [4:0] a, b, p;
    int failures = 0, compares = 0, cycles = 0, k;
    int ck [4] = '{3, 3, 2, 2};
    logic [4:0] ci [4] = '{5'h1d, 5'h1e, 5'h1e, 5'h00};
    logic [4:0] cg [4] = '{5'h03, 5'h04, 5'h04, 5'h02};

    rla_ctrl uut (
        .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .iface_sel_i(iface_sel_i),
        .ren_i(ren_i), .ser_char_i(ser_char_i), .bus_gtl_i(bus_gtl_i),
        .bus_addr_i(bus_addr_i), .panel_local_i(panel_local_i), .loc_pri_wr_i(loc_pri_wr_i),
        .loc_pri_addr_i(loc_pri_addr_i), .loc_sec_wr_i(loc_sec_wr_i),
        .loc_sec_idx_i(loc_sec_idx_i), .loc_sec_grp_i(loc_sec_grp_i),
        .rem_pri_wr_i(rem_pri_wr_i), .rem_pri_addr_i(rem_pri_addr_i),
        .rem_sec_wr_i(rem_sec_wr_i), .rem_sec_idx_i(rem_sec_idx_i),
        .rem_sec_grp_i(rem_sec_grp_i), .rem_compat_wr_i(rem_compat_wr_i),
        .rem_compat_val_i(rem_compat_val_i), .cmd_vld_i(cmd_vld_i),
        .cmd_hw_vld_i(cmd_hw_vld_i), .cmd_hw_sec_i(cmd_hw_sec_i),
        .cmd_pfx_vld_i(cmd_pfx_vld_i), .cmd_pfx_sec_i(cmd_pfx_sec_i),
        .sec_sel_vld_i(sec_sel_vld_i), .sec_sel_addr_i(sec_sel_addr_i),
        .sig_mode_i(sig_mode_i),
        .remote_o(remote_o), .panel_lock_o(panel_lock_o), .pri_addr_o(pri_addr_o),
        .addr_match_o(addr_match_o), .compat_o(compat_o), .active_sec_o(active_sec_o),
        .gen_off_o(gen_off_o), .sig_reset_o(sig_reset_o), .set_rej_o(set_rej_o),
        .route_vld_o(route_vld_o), .route_grp_o(route_grp_o), .route_err_o(route_err_o)
    );
    rla_host_model host (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .iface_sel_i(iface_sel_i),
        .want_rem_i(want_rem),
        .want_loc_i(want_loc),
        .ren_o(ren_i),
        .ser_char_o(ser_char_i),
        .bus_gtl_o(bus_gtl_i),
        .cmd_hw_vld_o(cmd_hw_vld_i)
    );

    // Free-running system clock
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end

    // A hang counts as a mismatch and closes the run
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            report_and_stop();
        end
    end

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    task automatic cyc();
        @(posedge clk_sys_i);
    endtask : cyc

    task automatic chk(input logic [5:0] seen, input logic [5:0] want);
        compares++;
        if (seen !== want) begin
            failures++;
            $display("BAD %0t seen %h expected %h", $time, seen, want);
        end
    endtask : chk

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    function automatic logic [4:0] pri_exp(input logic [4:0] old, input logic [4:0] x);
        return (x <= rla_pkg::RLA_PRI_MAX) ? x : old;
    endfunction : pri_exp

    // Remote writes may use index 30, the panel stops at 29
    function automatic logic sec_ok(input int kk, input logic [4:0] i, input logic [4:0] g);
        logic [4:0] top;
        top = (kk == 2) ? rla_pkg::RLA_SEC_MAX : rla_pkg::RLA_SEC_LOC_MAX;
        return g != rla_pkg::RLA_GRP_BASE && i >= 5'h01 && i <= top;
    endfunction : sec_ok

    task automatic strobe(input int kk, input logic v);
        case (kk)
            0: rem_pri_wr_i <= v;
            1: loc_pri_wr_i <= v;
            2: rem_sec_wr_i <= v;
            3: loc_sec_wr_i <= v;
            4: sec_sel_vld_i <= v;
            5: rem_compat_wr_i <= v;
            6: cmd_vld_i <= v;
            7: {cmd_vld_i, cmd_pfx_vld_i} <= {v, v};
            8: want_rem <= v;
            9: want_loc <= v;
            default: panel_local_i <= v;
        endcase
    endtask : strobe

    // One-cycle request; returns just after the edge that takes it
    task automatic fire(input int kk, input logic [4:0] x, input logic [4:0] y);
        cyc();
        {rem_pri_addr_i, loc_pri_addr_i, rem_sec_idx_i, loc_sec_idx_i} <= {4{x}};
        {sec_sel_addr_i, cmd_pfx_sec_i, cmd_hw_sec_i} <= {3{x}};
        {rem_sec_grp_i, loc_sec_grp_i} <= {2{y}};
        rem_compat_val_i <= y[0];
        strobe(kk, 1'b1);
        cyc();
        strobe(kk, 1'b0);
        #1;
    endtask : fire

    task automatic wait_rem(input logic e);
        int n;
        n = 0;
        while (remote_o !== e && n < 8) begin
            cyc();
            #1;
            n++;
        end
    endtask : wait_rem

    task automatic report_and_stop();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {iface_sel_i, panel_local_i, loc_pri_wr_i, loc_sec_wr_i, rem_pri_wr_i, rem_sec_wr_i,
            rem_compat_wr_i, rem_compat_val_i, cmd_vld_i, cmd_pfx_vld_i, sec_sel_vld_i,
            sig_mode_i, want_rem, want_loc, bus_addr_i, loc_pri_addr_i, loc_sec_idx_i,
            loc_sec_grp_i, rem_pri_addr_i, rem_sec_idx_i, rem_sec_grp_i, cmd_hw_sec_i,
            cmd_pfx_sec_i, sec_sel_addr_i} = '0;
        sys_rst_i = 1'b1;
        rng = 32'h04dd;
        p = rla_pkg::RLA_PRI_RST;
        foreach (tbl[i]) tbl[i] = 5'h00;
        tbl[0] = rla_pkg::RLA_GRP_BASE;
        repeat (12) cyc();
        sys_rst_i <= 1'b0;
        #1;
        chk(remote_o | panel_lock_o, 1'b0);
        chk(pri_addr_o, p);
        chk(active_sec_o, 5'h00);
        $display("test reset finished");
        // Primary address: 30 and 31 first, then random panel and remote writes
        for (int i = 0; i < 14; i++) begin
            rng = lfsr(rng);
            a = (i < 2) ? 5'h1e + i[4:0] : rng[4:0];
            k = (i < 2) ? 0 : int'(rng[8]);
            fire(k, a, 5'h00);
            p = pri_exp(p, a);
            chk(pri_addr_o, p);
            chk(set_rej_o, k == 0 && a > rla_pkg::RLA_PRI_MAX);
        end
        cyc();
        bus_addr_i <= p;
        repeat (2) cyc();
        #1;
        chk(addr_match_o, 1'b1);
        cyc();
        bus_addr_i <= p ^ 5'h01;
        repeat (2) cyc();
        #1;
        chk(addr_match_o, 1'b0);
        $display("test primary finished");
        // Secondary table: index edges first, each write followed by a routed command
        for (int i = 0; i < 16; i++) begin
            rng = lfsr(rng);
            a = (i < 4) ? ci[i] : rng[4:0];
            b = (i < 4) ? cg[i] : rng[12:8];
            k = (i < 4) ? ck[i] : 2 + int'(rng[16]);
            fire(k, a, b);
            chk(set_rej_o, k == 2 && !sec_ok(k, a, b));
            if (sec_ok(k, a, b)) tbl[a] = b;
            fire(7, a, 5'h00);
            chk(route_vld_o, tbl[a] != 5'h00);
            chk(route_err_o, tbl[a] == 5'h00);
            if (tbl[a] != 5'h00) chk(route_grp_o, tbl[a]);
        end
        $display("test secondary finished");
        // Serial select command versus prefix routing
        cyc();
        iface_sel_i <= 1'b1;
        fire(2, 5'h05, 5'h07);
        fire(4, 5'h05, 5'h00);
        chk(active_sec_o, 5'h05);
        fire(7, 5'h00, 5'h00);
        chk(route_grp_o, rla_pkg::RLA_GRP_BASE);
        fire(6, 5'h00, 5'h00);
        chk(route_grp_o, 5'h07);
        fire(4, 5'h1f, 5'h00);
        chk({set_rej_o, active_sec_o}, 6'h25);
        fire(2, 5'h05, 5'h00);
        fire(6, 5'h00, 5'h00);
        chk({route_vld_o, route_err_o}, 2'b01);
        $display("test select finished");
        // Serial entry, non-signalling, compatible mode; panel locked out
        fire(8, 5'h00, 5'h00);
        wait_rem(1'b1);
        chk({remote_o, panel_lock_o}, 2'b11);
        chk({gen_off_o, sig_reset_o}, 2'b10);
        fire(1, 5'h03, 5'h00);
        chk({gen_off_o, pri_addr_o}, {1'b0, p});
        fire(10, 5'h00, 5'h00);
        wait_rem(1'b0);
        chk(remote_o, 1'b0);
        // Bus entry by REN in signalling mode, back to local by go-to-local
        cyc();
        iface_sel_i <= 1'b0;
        sig_mode_i <= 1'b1;
        fire(8, 5'h00, 5'h00);
        wait_rem(1'b1);
        chk(remote_o, 1'b1);
        chk({gen_off_o, sig_reset_o}, 2'b01);
        fire(9, 5'h00, 5'h00);
        wait_rem(1'b0);
        chk(remote_o, 1'b0);
        // Compatibility off keeps generator and signalling states
        fire(5, 5'h00, 5'h00);
        chk(compat_o, 1'b0);
        fire(8, 5'h00, 5'h00);
        wait_rem(1'b1);
        chk({remote_o, gen_off_o, sig_reset_o}, 3'b100);
        $display("test remote finished");
        report_and_stop();
    end
endmodule : tb_remote_local_address_control
